// ==== rtl/scd_core.sv ====
// Serial interface core of the current converter
`timescale 1ns/100ps
`include "scd_regs.svh"

// Behaviour
// - Serial data input is shifted in on each rising edge of the serial clock.
// - A rising load strobe copies the shift register into the converter register.
// - Serial output data changes on falling serial clock edges in readback or chain.
// - While the floor input is high the output code is forced to the range bottom.
// - Alert goes low on open circuit in current mode or on over-temperature.
// - Alert is open drain: only driven low, released otherwise.
// - The shift register is 24 bits, MSB first, 8-bit address above 16-bit data.
// - Shifting ignores the strobe; the last 24 bits before its rising edge are taken.
// - Address codes select nop, data, readback, control and reset registers.
module scd_core
    import scd_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // Serial link pins, asynchronous to mclk
    input  wire scd_pkg::scd_pins_s pins,
    // Fault detectors from the analogue side
    input  wire scd_pkg::scd_fault_s fault,
    input  wire logic              currentMode,
    // Serial data output pin
    output logic                   serialDataOut,
    output logic                   serialDataOe,
    // Open-drain alert pin
    output logic                   alertOut,
    output logic                   alertOe,
    // Converter side
    output logic [15:0]            dacCode,
    output logic [15:0]            ctrlReg,
    output logic                   outputFloor
);
    import scd_pkg::*;

    logic [3:0] pinSync;
    logic [1:0] faultSync;
    logic       sclkS, sdinS, latchS, floorS;
    logic       sclkPrev_r, latchPrev_r;
    logic       sclkRise, sclkFall, latchRise;

    logic [23:0] shift_r, shift_nxt;
    logic [15:0] data_r, data_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [23:0] rdbk_r, rdbk_nxt;
    logic        rbMode_r, rbMode_nxt;
    logic        sdo_r, sdo_nxt;
    logic        sdoOe_r, sdoOe_nxt;
    logic        alertOe_r, alertOe_nxt;
    logic        floor_r, floor_nxt;
    logic [15:0] code_r, code_nxt;
    scd_word_s   word;
    // Readback value picked at the strobe, before it enters the output shifter
    logic [23:0] rbVal;

    // Pins pass two flops before anything reads them
    scd_sync #(.W(4)) uPinSync (
        .mclk (mclk),
        .rstn (rstn),
        .din  ({pins.sclk, pins.serial_data_in, pins.latch, pins.floor}),
        .dout (pinSync)
    );
    scd_sync #(.W(2)) uFaultSync (
        .mclk (mclk),
        .rstn (rstn),
        .din  ({fault.openCircuit, fault.overTemp}),
        .dout (faultSync)
    );

    assign sclkS  = pinSync[3];
    assign sdinS  = pinSync[2];
    assign latchS = pinSync[1];
    assign floorS = pinSync[0];

    // Edge detection on synchronised copies; a 30 MHz link is too fast for
    // a 25 MHz sampler; the bench link at 320 ns per bit stays well inside the limit
    assign sclkRise  = sclkS & ~sclkPrev_r;
    assign sclkFall  = ~sclkS & sclkPrev_r;
    assign latchRise = latchS & ~latchPrev_r;
    assign word      = shift_r;

    // Next-state logic for the shift path and registers
    always_comb begin
        shift_nxt   = shift_r;
        data_nxt    = data_r;
        ctrl_nxt    = ctrl_r;
        rdbk_nxt    = rdbk_r;
        rbMode_nxt  = rbMode_r;
        sdo_nxt     = sdo_r;
        sdoOe_nxt   = sdoOe_r;
        // Read select: 0 data, 1 control, otherwise status
        rbVal       = {8'h00, (word.data[1:0] == 2'd0) ? data_r :
                       (word.data[1:0] == 2'd1) ? ctrl_r :
                       {14'h0000, faultSync}};
        // Shift regardless of strobe level, MSB first
        if (sclkRise) begin
            shift_nxt = {shift_r[22:0], sdinS};
        end
        // Output changes on falling clock, from readback or chain data; a readback strobe also sets it
        if (sclkFall && (rbMode_r || ctrl_r[`SCD_CTRL_DCEN])) begin
            sdo_nxt   = rbMode_r ? rdbk_r[23] : shift_r[23];
            sdoOe_nxt = 1'b1;
            if (rbMode_r) begin
                rdbk_nxt = {rdbk_r[22:0], 1'b0};
            end
        end
        // Strobe takes the word; undefined addresses fall through untouched
        if (latchRise) begin
            rbMode_nxt = 1'b0;
            sdoOe_nxt  = ctrl_r[`SCD_CTRL_DCEN];
            if (word.addr == `SCD_ADDR_DATA) begin
                data_nxt = word.data;
            end else if (word.addr == `SCD_ADDR_CTRL) begin
                ctrl_nxt = word.data;
            end else if (word.addr == `SCD_ADDR_RST) begin
                if (word.data[0]) begin
                    data_nxt = `SCD_DATA_RST;
                    ctrl_nxt = `SCD_CTRL_RST;
                end
            end else if (word.addr == `SCD_ADDR_RDBK) begin
                // First bit stands from the strobe, so 24 clocks carry all 24 bits
                rbMode_nxt = 1'b1;
                sdo_nxt    = rbVal[23];
                sdoOe_nxt  = 1'b1;
                rdbk_nxt   = {rbVal[22:0], 1'b0};
            end
            // NOP and undefined codes leave data and control alone; the strobe still ends readback and reloads the output enable from the chain enable bit
        end
    end

    // Output side: floor forcing and open-drain alert
    always_comb begin
        floor_nxt   = floorS;
        code_nxt    = floorS ? `SCD_FLOOR_ZERO : data_r;
        alertOe_nxt = (faultSync[1] & currentMode) | faultSync[0];
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sclkPrev_r  <= 1'b0;
            latchPrev_r <= 1'b0;
            shift_r     <= 24'h00_0000;
            data_r      <= `SCD_DATA_RST;
            ctrl_r      <= `SCD_CTRL_RST;
            rdbk_r      <= 24'h00_0000;
            rbMode_r    <= 1'b0;
            sdo_r       <= 1'b0;
            sdoOe_r     <= 1'b0;
            alertOe_r   <= 1'b0;
            floor_r     <= 1'b0;
            code_r      <= `SCD_DATA_RST;
        end else begin
            sclkPrev_r  <= sclkS;
            latchPrev_r <= latchS;
            shift_r     <= shift_nxt;
            data_r      <= data_nxt;
            ctrl_r      <= ctrl_nxt;
            rdbk_r      <= rdbk_nxt;
            rbMode_r    <= rbMode_nxt;
            sdo_r       <= sdo_nxt;
            sdoOe_r     <= sdoOe_nxt;
            alertOe_r   <= alertOe_nxt;
            floor_r     <= floor_nxt;
            code_r      <= code_nxt;
        end
    end

    // Ports straight from flops; alert data is constant low
    assign serialDataOut = sdo_r;
    assign serialDataOe  = sdoOe_r;
    assign alertOut      = 1'b0;
    assign alertOe       = alertOe_r;
    assign dacCode       = code_r;
    assign ctrlReg       = ctrl_r;
    assign outputFloor   = floor_r;

    // Assertions
    sequence latchSeen;
        latchRise && !rbMode_r;
    endsequence

    shift_on_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
        sclkRise |=> shift_r[0] == $past(sdinS))
        else $error("shift did not take data bit");
    shift_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !sclkRise |=> shift_r == $past(shift_r))
        else $error("shift changed without clock edge");
    data_load_a: assert property (@(posedge mclk) disable iff (!rstn)
        latchSeen and (word.addr == 8'h01) |=> data_r == $past(word.data))
        else $error("data register not loaded");
    ctrl_load_a: assert property (@(posedge mclk) disable iff (!rstn)
        latchRise && word.addr == 8'h55 |=> ctrl_r == $past(word.data))
        else $error("control register not loaded");
    bad_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        latchRise && word.addr != 8'h01 && word.addr != 8'h55 && word.addr != 8'h56
        |=> data_r == $past(data_r) && ctrl_r == $past(ctrl_r))
        else $error("undefined address changed state");
    sdo_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
        !sclkFall && !latchRise |=> sdo_r == $past(sdo_r))
        else $error("serial out changed off falling edge");
    floor_force_a: assert property (@(posedge mclk) disable iff (!rstn)
        floorS |=> dacCode == 16'h0000)
        else $error("floor not forced");
    alert_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
        faultSync[0] |=> alertOe)
        else $error("alert not asserted on over-temperature");
    alert_od_a: assert property (@(posedge mclk) disable iff (!rstn)
        alertOut == 1'b0)
        else $error("alert drove high");
    alert_release_a: assert property (@(posedge mclk) disable iff (!rstn)
        !faultSync[0] && !(faultSync[1] && currentMode) |=> !alertOe)
        else $error("alert held low without a fault");
    rdbk_start_a: assert property (@(posedge mclk) disable iff (!rstn)
        latchRise && word.addr == 8'h02 |=> serialDataOe && rbMode_r)
        else $error("readback did not start driving serial out");
endmodule

// ==== rtl/scd_regs.svh ====
// Constants for the serial current converter interface
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
`define SCD_WORD_W     24
`define SCD_ADDR_W     8
`define SCD_DATA_W     16
`define SCD_ADDR_NOP   8'h00
`define SCD_ADDR_DATA  8'h01
`define SCD_ADDR_RDBK  8'h02
`define SCD_ADDR_CTRL  8'h55
`define SCD_ADDR_RST   8'h56
`define SCD_DATA_RST   16'h0000
`define SCD_CTRL_RST   16'h0000
// Control field positions: range select bits, daisy-chain enable bit
`define SCD_CTRL_RANGE_LO 0
`define SCD_CTRL_DCEN     3
// Readback select positions in data word of a readback request
`define SCD_RB_SEL_LO  0
// Code written to the reset register that triggers a soft reset
`define SCD_RST_KEY    16'h0001
// Lowest output code, the same for every range (0-20, 0-24 and 4-20 style floors)
`define SCD_FLOOR_ZERO 16'h0000
`endif

// ==== rtl/scd_pkg.sv ====
// Types for the serial current converter interface
package scd_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
    } scd_word_s;
    typedef struct packed {
        logic sclk;
        logic serial_data_in;
        logic latch;
        logic floor;
    } scd_pins_s;
    typedef struct packed {
        logic openCircuit;
        logic overTemp;
    } scd_fault_s;
endpackage

// ==== rtl/scd_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module scd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // Next values: first stage only feeds the second
    always_comb begin
        meta_nxt = din;
        sync_nxt = meta_r;
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign dout = sync_r;
endmodule

// ==== testbench/scd_host_model.sv ====
// Host-side model that clocks words into the converter interface
`timescale 1ns/100ps
module scd_host_model (
    // Clock the model paces itself by
    input  wire logic        mclk,
    // Serial link pins toward the converter
    output logic             sclk,
    output logic             serial_data_in,
    output logic             latch,
    input  wire logic        serial_data_out,
    // Serial output bits seen just before each falling edge
    output logic [23:0]      sdoCap
);
    // Link idles with clock and strobe low
    initial begin
        sclk = 1'b0;
        serial_data_in = 1'b0;
        latch = 1'b0;
        sdoCap = 24'h00_0000;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Eight mclk per bit keeps the link well under the sampling limit
    task automatic shiftWord(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data_in = w[i];
            tick(2);
            sclk = 1'b1;
            tick(4);
            sdoCap = {sdoCap[22:0], serial_data_out};
            sclk = 1'b0;
            // Released data line must not keep showing the last bit
            if (i == 0) begin
                serial_data_in = ~w[0];
            end
            tick(2);
        end
    endtask

    // Strobe comes well after the last rising clock edge
    task automatic pulseLatch();
        tick(4);
        latch = 1'b1;
        tick(4);
        latch = 1'b0;
        tick(2);
    endtask
endmodule

// ==== testbench/tb_serial_current_dac_interface.sv ====
// Self-checking bench for the converter serial interface core
`timescale 1ns/100ps
`include "scd_regs.svh"
module tb_serial_current_dac_interface;
    import scd_pkg::*;
    logic        mclk, rstn, floorPin, currentMode, sclk, serial_data_in, latch;
    logic        serialDataOut, serialDataOe, alertOut, alertOe, outputFloor;
    logic [15:0] dacCode, ctrlReg, expDac, expCtrl;
    logic [23:0] sdoCap, w1, w2;
    logic [31:0] r;
    scd_fault_s  fault;
    int          errCount, comparisons;
    int          seed = 10;

    always #20 mclk = ~mclk;

    scd_host_model i_host (.mclk(mclk), .sclk(sclk), .serial_data_in(serial_data_in), .latch(latch),
        .serial_data_out(serialDataOut), .sdoCap(sdoCap));
    scd_core i_dut (.mclk(mclk), .rstn(rstn), .pins({sclk, serial_data_in, latch, floorPin}),
        .fault(fault), .currentMode(currentMode), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .alertOut(alertOut), .alertOe(alertOe),
        .dacCode(dacCode), .ctrlReg(ctrlReg), .outputFloor(outputFloor));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Expected register contents after a latched word
    function automatic logic [15:0] nextReg(input logic [23:0] w, input logic [15:0] cur,
                                            input logic [7:0] a);
        if (w[23:16] == a)
            return w[15:0];
        if (w[23:16] == `SCD_ADDR_RST && w[0])
            return 16'h0000;
        return cur;
    endfunction

    // Expected readback value for a read select code
    function automatic logic [15:0] rbExp(input logic [1:0] sel);
        if (sel == 2'd0)
            return expDac;
        if (sel == 2'd1)
            return expCtrl;
        return {14'h0000, fault.openCircuit, fault.overTemp};
    endfunction

    task automatic send(input logic [23:0] w);
        i_host.shiftWord(w);
        i_host.pulseLatch();
        i_host.tick(8);
        expDac = nextReg(w, expDac, `SCD_ADDR_DATA);
        expCtrl = nextReg(w, expCtrl, `SCD_ADDR_CTRL);
        check(dacCode, expDac);
        check(ctrlReg, expCtrl);
    endtask

    // Hang guard
    initial begin
        #4_000_000;
        errCount++;
        summarize();
    end

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        floorPin = 1'b0;
        currentMode = 1'b0;
        fault = '0;
        expDac = 16'h0000;
        expCtrl = 16'h0000;
        repeat (6) @(posedge mclk);
        #1 rstn = 1'b1;
        i_host.tick(4);
        check(dacCode, 16'h0000);
        check(alertOe, 1'b0);
        // Random data writes, each after a stray unlatched word
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            i_host.shiftWord(r[31:8]);
            r = $random(seed);
            send({`SCD_ADDR_DATA, r[15:0]});
        end
        $display("data writes done");
        // Every address kind, an undefined one and a non-key reset among them
        for (int i = 0; i < 9; i++) begin
            r = $random(seed);
            case (i)
                0: w1 = {`SCD_ADDR_CTRL, r[15:4], 1'b0, r[2:0]};
                1: w1 = {`SCD_ADDR_NOP, r[15:0]};
                2: w1 = {`SCD_ADDR_RDBK, 14'h0000, r[1:0]};
                3: w1 = {1'b1, r[22:0]};
                4: w1 = {`SCD_ADDR_RST, 16'h0002};
                5: w1 = {`SCD_ADDR_RST, `SCD_RST_KEY};
                default: w1 = {`SCD_ADDR_DATA, r[15:0]};
            endcase
            send(w1);
        end
        $display("address decode done");
        // Floor forces code zero and releases to the held code
        floorPin = 1'b1;
        i_host.tick(6);
        check(dacCode, 16'h0000);
        check(outputFloor, 1'b1);
        floorPin = 1'b0;
        i_host.tick(6);
        check(dacCode, expDac);
        $display("floor done");
        // Alert for every fault and mode combination
        for (int i = 0; i < 8; i++) begin
            {fault.openCircuit, fault.overTemp, currentMode} = i[2:0];
            i_host.tick(6);
            check(alertOe, fault.overTemp | (fault.openCircuit & currentMode));
            check(alertOut, 1'b0);
        end
        fault = '0;
        $display("alert done");
        // Chain mode passes the previous word out on the serial output
        send({`SCD_ADDR_CTRL, 16'h0008});
        r = $random(seed);
        w1 = r[23:0];
        r = $random(seed);
        w2 = {`SCD_ADDR_DATA, r[15:0]};
        i_host.shiftWord(w1);
        send(w2);
        check(sdoCap, w1);
        check(serialDataOe, 1'b1);
        $display("daisy chain done");
        // Readback of each select comes out during the following word
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            fault = r[1:0];
            send({`SCD_ADDR_RDBK, 14'h0000, i[1:0]});
            send({`SCD_ADDR_NOP, r[31:16]});
            check(sdoCap, {8'h00, rbExp(i[1:0])});
            check(serialDataOe, expCtrl[`SCD_CTRL_DCEN]);
        end
        fault = '0;
        $display("readback done");
        // Reset in mid-run clears the registers and the output enable
        rstn = 1'b0;
        repeat (6) @(posedge mclk);
        #1 rstn = 1'b1;
        i_host.tick(4);
        expDac = 16'h0000;
        expCtrl = 16'h0000;
        check(dacCode, expDac);
        check(ctrlReg, expCtrl);
        check(serialDataOe, 1'b0);
        r = $random(seed);
        send({`SCD_ADDR_DATA, r[15:0]});
        $display("mid-run reset done");
        summarize();
    end
endmodule
